// file: hdl/acf_cmd_fetch.sv
`timescale 1ns/1ps
module acf_cmd_fetch #(
	parameter int LIST1_OFFSET = 'h100
)(
	// clock and reset
	input wire logic sys_clk,
	input wire logic resetn,
	// apb slave
	input acf_pkg::acf_apb_req_t apbReq,
	output logic pready,
	output logic [acf_pkg::ACF_DATA_W-1:0] prdata,
	output logic pslverr,
	// command memory
	output acf_pkg::acf_fetch_t fetch,
	input wire logic fetchAck,
	input wire logic [acf_pkg::ACF_DATA_W-1:0] fetchData,
	// converter status
	output logic sampling,
	output logic halted
);
	import acf_pkg::*;

	function automatic logic decHit(input logic [ACF_ADDR_W-1:0] a, input logic [ACF_ADDR_W-1:0] r);
		decHit = (a == r);
	endfunction

	logic [ACF_DATA_W-1:0] ctrl_r, ctrl_nxt;
	logic err_r, err_nxt;
	logic [ACF_CMD2_W-1:0] cmd2_r, cmd2_nxt;
	logic [ACF_PTR_W-1:ACF_PTR_LSB] cbp_r, cbp_nxt;
	logic [ACF_DATA_W-1:0] rdata_r, rdata_nxt;
	logic slverr_r, slverr_nxt;
	acf_state_t state_r, state_nxt;
	logic [ACF_CIDX_W-1:0] cidx_r, cidx_nxt;
	logic [ACF_PRESC_W-1:0] div_r, div_nxt;
	logic [ACF_CNT_W-1:0] sampCnt_r, sampCnt_nxt;

	logic setup, wrAcc, enable, smod, tick, cmdBad, loadCmd;
	logic [ACF_PRESC_W-1:0] presc;
	logic [ACF_SAMP_W-1:0] sampleCode;
	logic [ACF_CNT_W-1:0] sampleLen;
	logic [ACF_PTR_W-1:0] listOff;
	logic [ACF_CMD2_W-1:0] fetchedCmd;

	assign setup = apbReq.psel && !apbReq.penable;
	assign wrAcc = apbReq.psel && apbReq.penable && apbReq.pwrite;
	assign enable = ctrl_r[ACF_CTRL_EN];
	assign smod = ctrl_r[ACF_CTRL_SMOD];
	assign presc = ctrl_r[ACF_CTRL_PRESC_LSB +: ACF_PRESC_W];
	assign pready = 1'b1;
	assign prdata = rdata_r;
	assign pslverr = slverr_r;
	assign fetchedCmd = fetchData[ACF_CMD2_LSB +: ACF_CMD2_W];
	assign sampleCode = cmd2_r[ACF_SAMP_LSB +: ACF_SAMP_W];
	assign sampleLen = ACF_CNT_W'(sampleCode) + ACF_CNT_W'(ACF_SAMP_BASE);
	assign loadCmd = (state_r == ST_FETCH) && fetchAck;
	assign cmdBad = (fetchedCmd[ACF_SAMP_LSB +: ACF_SAMP_W] > ACF_SAMP_MAX)
		|| (fetchedCmd[ACF_RSV_W-1:0] != '0);
	assign tick = (div_r == presc);
	assign listOff = ctrl_r[ACF_CTRL_LIST] ? ACF_PTR_W'(LIST1_OFFSET) : '0;
	assign fetch.req = (state_r == ST_FETCH);
	assign fetch.addr = {cbp_r, ACF_PTR_LSB'(0)} + listOff
		+ ACF_PTR_W'(cidx_r * ACF_WORD_BYTES);
	assign sampling = (state_r == ST_SAMPLE);
	assign halted = (state_r == ST_HALT);

	// register file and bus answer
	always_comb
	begin
		ctrl_nxt = ctrl_r;
		err_nxt = err_r;
		cmd2_nxt = cmd2_r;
		cbp_nxt = cbp_r;
		rdata_nxt = rdata_r;
		slverr_nxt = slverr_r;
		if (setup)
		begin
			rdata_nxt = ACF_RST_ZERO;
			slverr_nxt = 1'b0;
			case (apbReq.paddr)
				ACF_A_CTRL: rdata_nxt = ctrl_r;
				ACF_A_STAT:
				begin
					rdata_nxt[ACF_STAT_ERR] = err_r;
					rdata_nxt[ACF_STAT_BUSY] = (state_r != ST_IDLE);
				end
				ACF_A_CMD2: rdata_nxt[ACF_CMD2_W-1:0] = cmd2_r;
				ACF_A_CIDX: rdata_nxt[ACF_CIDX_W-1:0] = cidx_r;
				ACF_A_CBP: rdata_nxt[ACF_PTR_W-1:ACF_PTR_LSB] = cbp_r;
				default: slverr_nxt = 1'b1;
			endcase
		end
		if (wrAcc)
		begin
			if (decHit(apbReq.paddr, ACF_A_CTRL))
			begin
				ctrl_nxt = ACF_RST_ZERO;
				ctrl_nxt[ACF_CTRL_EN] = apbReq.pwdata[ACF_CTRL_EN];
				ctrl_nxt[ACF_CTRL_SMOD] = apbReq.pwdata[ACF_CTRL_SMOD];
				ctrl_nxt[ACF_CTRL_LIST] = apbReq.pwdata[ACF_CTRL_LIST];
				ctrl_nxt[ACF_CTRL_PRESC_LSB +: ACF_PRESC_W] =
					apbReq.pwdata[ACF_CTRL_PRESC_LSB +: ACF_PRESC_W];
			end
			if (decHit(apbReq.paddr, ACF_A_STAT) && apbReq.pwdata[ACF_STAT_ERR])
				err_nxt = 1'b0;
			if (decHit(apbReq.paddr, ACF_A_CMD2) && smod)
				cmd2_nxt = apbReq.pwdata[ACF_CMD2_W-1:0];
			if (decHit(apbReq.paddr, ACF_A_CBP) && (!enable || smod))
				cbp_nxt = apbReq.pwdata[ACF_PTR_W-1:ACF_PTR_LSB];
		end
		if (loadCmd)
			cmd2_nxt = fetchedCmd;
		if (loadCmd && cmdBad)
			err_nxt = 1'b1;
	end

	always_ff @(posedge sys_clk or negedge resetn)
	begin
		if (!resetn)
		begin
			ctrl_r <= ACF_RST_ZERO;
			err_r <= 1'b0;
			cmd2_r <= '0;
			cbp_r <= '0;
			rdata_r <= ACF_RST_ZERO;
			slverr_r <= 1'b0;
		end
		else
		begin
			ctrl_r <= ctrl_nxt;
			err_r <= err_nxt;
			cmd2_r <= cmd2_nxt;
			cbp_r <= cbp_nxt;
			rdata_r <= rdata_nxt;
			slverr_r <= slverr_nxt;
		end
	end

	// command sequencer and conversion clock divider
	always_comb
	begin
		state_nxt = state_r;
		cidx_nxt = cidx_r;
		sampCnt_nxt = sampCnt_r;
		div_nxt = (tick || !enable) ? '0 : div_r + 1'b1;
		case (state_r)
			ST_IDLE:
			begin
				cidx_nxt = '0;
				if (enable && !err_r)
					state_nxt = ST_FETCH;
			end
			ST_FETCH:
			begin
				sampCnt_nxt = '0;
				if (fetchAck)
					state_nxt = cmdBad ? ST_HALT : ST_SAMPLE;
			end
			ST_SAMPLE:
				if (tick)
				begin
					sampCnt_nxt = sampCnt_r + 1'b1;
					if (sampCnt_r + 1'b1 == sampleLen)
						state_nxt = ST_NEXT;
				end
			ST_NEXT:
			begin
				cidx_nxt = cidx_r + 1'b1;
				state_nxt = ST_FETCH;
			end
			ST_HALT:
				if (!err_r)
					state_nxt = ST_IDLE;
			default: state_nxt = ST_IDLE;
		endcase
		if (!enable && state_r != ST_FETCH)
			state_nxt = ST_IDLE;
	end

	always_ff @(posedge sys_clk or negedge resetn)
	begin
		if (!resetn)
		begin
			state_r <= ST_IDLE;
			cidx_r <= '0;
			div_r <= '0;
			sampCnt_r <= '0;
		end
		else
		begin
			state_r <= state_nxt;
			cidx_r <= cidx_nxt;
			div_r <= div_nxt;
			sampCnt_r <= sampCnt_nxt;
		end
	end

	// checks
	default clocking cb @(posedge sys_clk); endclocking
	default disable iff (!resetn);

	// helpers: cycles since the last tick, sys clocks spent sampling, bounds
	localparam int SPAN_W = ACF_CNT_W + ACF_PRESC_W;
	logic [ACF_CNT_W-1:0] gap_r, gap_nxt;
	logic [SPAN_W-1:0] span_r, span_nxt, spanHi, spanLo;
	logic [ACF_CNT_W-1:0] codeLen;
	logic spanOk, errClear, cidxLocked;

	always_comb
	begin
		gap_nxt = (tick || !enable) ? '0 : gap_r + 1'b1;
		span_nxt = sampling ? span_r + 1'b1 : '0;
		codeLen = ACF_CNT_W'(cmd2_r[ACF_SAMP_LSB +: ACF_SAMP_W])
			+ ACF_CNT_W'(ACF_SAMP_BASE);
		// n ticks of period p+1 take between n*(p+1)-p and n*(p+1) sys clocks
		spanHi = SPAN_W'(codeLen) * (SPAN_W'(presc) + 1'b1);
		spanLo = spanHi - SPAN_W'(presc);
		spanOk = (span_r + 1'b1 >= spanLo) && (span_r + 1'b1 <= spanHi);
		errClear = wrAcc && decHit(apbReq.paddr, ACF_A_STAT)
			&& apbReq.pwdata[ACF_STAT_ERR];
		cidxLocked = (state_r != ST_NEXT) && (state_r != ST_IDLE || cidx_r == '0);
	end

	always_ff @(posedge sys_clk or negedge resetn)
	begin
		if (!resetn)
		begin
			gap_r <= '0;
			span_r <= '0;
		end
		else
		begin
			gap_r <= gap_nxt;
			span_r <= span_nxt;
		end
	end

	sequence badLoad;
		loadCmd && cmdBad;
	endsequence
	sequence goodLoad;
		loadCmd && !cmdBad;
	endsequence
	sequence sampleEnds;
		sampling && tick && (sampCnt_r + 1'b1 == sampleLen);
	endsequence
	sequence nextFetch;
		state_r == ST_NEXT ##1 fetch.req;
	endsequence

	// error and halt
	chk_bad_halts: assert property (badLoad |=> (halted && err_r && !fetch.req) [*2])
		else $error("reserved command did not halt");
	chk_err_sticky: assert property (err_r && !errClear |=> err_r)
		else $error("command error flag dropped without a clear");
	chk_halt_idle: assert property (halted && err_r |=> !fetch.req)
		else $error("fetch while halted");

	// register access guards
	chk_cmd2_guard: assert property (wrAcc && decHit(apbReq.paddr, ACF_A_CMD2)
		&& !smod && !loadCmd |=> $stable(cmd2_r))
		else $error("command register written without special access");
	chk_cmd2_write: assert property (wrAcc && decHit(apbReq.paddr, ACF_A_CMD2)
		&& smod && !loadCmd |=> cmd2_r == $past(apbReq.pwdata[ACF_CMD2_W-1:0]))
		else $error("command register write under special access lost");
	chk_cbp_guard: assert property (wrAcc && decHit(apbReq.paddr, ACF_A_CBP)
		&& enable && !smod |=> $stable(cbp_r))
		else $error("base pointer written while locked");
	chk_cbp_open: assert property (wrAcc && decHit(apbReq.paddr, ACF_A_CBP)
		&& (!enable || smod) |=> cbp_r == $past(apbReq.pwdata[ACF_PTR_W-1:ACF_PTR_LSB]))
		else $error("base pointer write lost");

	// conversion clock and sample phase
	chk_tick_period: assert property (enable && tick |-> gap_r == ACF_CNT_W'(presc))
		else $error("conversion clock period wrong");
	chk_good_samples: assert property (goodLoad |=> sampling)
		else $error("valid command did not start sampling");
	chk_sample_len: assert property (sampleEnds |-> spanOk ##1 nextFetch)
		else $error("sample phase length wrong");

	// command position and fetch address
	chk_idx_step: assert property (state_r == ST_NEXT |=> cidx_r == $past(cidx_r) + 1'b1)
		else $error("command position step wrong");
	chk_idx_hold: assert property (state_r == ST_FETCH || state_r == ST_SAMPLE
		|=> $stable(cidx_r))
		else $error("command position moved during a command");
	chk_idx_ro: assert property (wrAcc && decHit(apbReq.paddr, ACF_A_CIDX)
		&& cidxLocked |=> $stable(cidx_r))
		else $error("command position changed by a write");
	chk_fetch_base: assert property (fetch.req && cidx_r == '0
		|-> fetch.addr == {cbp_r, ACF_PTR_LSB'(0)} + listOff)
		else $error("first fetch not at list start");
	chk_fetch_hold: assert property (fetch.req && !fetchAck |=> fetch.req
		&& $stable(fetch.addr) && fetch.addr[ACF_PTR_LSB-1:0] == '0)
		else $error("fetch request dropped or address moved");
endmodule

// file: hdl/acf_pkg.sv
package acf_pkg;
	// bus geometry
	localparam int ACF_DATA_W = 32;
	localparam int ACF_ADDR_W = 8;
	localparam int ACF_WORD_BYTES = 4;
	// register indices, byte address is index times word size
	localparam int ACF_IDX_CTRL = 'h01;
	localparam int ACF_IDX_STAT = 'h02;
	localparam int ACF_IDX_CMD2 = 'h16;
	localparam int ACF_IDX_CIDX = 'h1c;
	localparam int ACF_IDX_CBP = 'h1d;
	localparam logic [ACF_ADDR_W-1:0] ACF_A_CTRL = ACF_ADDR_W'(ACF_IDX_CTRL * ACF_WORD_BYTES);
	localparam logic [ACF_ADDR_W-1:0] ACF_A_STAT = ACF_ADDR_W'(ACF_IDX_STAT * ACF_WORD_BYTES);
	localparam logic [ACF_ADDR_W-1:0] ACF_A_CMD2 = ACF_ADDR_W'(ACF_IDX_CMD2 * ACF_WORD_BYTES);
	localparam logic [ACF_ADDR_W-1:0] ACF_A_CIDX = ACF_ADDR_W'(ACF_IDX_CIDX * ACF_WORD_BYTES);
	localparam logic [ACF_ADDR_W-1:0] ACF_A_CBP = ACF_ADDR_W'(ACF_IDX_CBP * ACF_WORD_BYTES);
	// control and status fields
	localparam int ACF_CTRL_EN = 0;
	localparam int ACF_CTRL_SMOD = 1;
	localparam int ACF_CTRL_LIST = 2;
	localparam int ACF_CTRL_PRESC_LSB = 8;
	localparam int ACF_PRESC_W = 7;
	localparam int ACF_STAT_ERR = 0;
	localparam int ACF_STAT_BUSY = 1;
	// command word layout, command register holds command bits 15:8
	localparam int ACF_CMD2_W = 8;
	localparam int ACF_CMD2_LSB = 8;
	localparam int ACF_SAMP_LSB = 3;
	localparam int ACF_SAMP_W = 5;
	localparam int ACF_RSV_W = 3;
	localparam int ACF_SAMP_BASE = 4;
	localparam logic [ACF_SAMP_W-1:0] ACF_SAMP_MAX = 5'h14;
	// list addressing
	localparam int ACF_CIDX_W = 6;
	localparam int ACF_PTR_W = 24;
	localparam int ACF_PTR_LSB = 2;
	localparam int ACF_CNT_W = 8;
	// reset values
	localparam logic [ACF_DATA_W-1:0] ACF_RST_ZERO = 32'h0;

	typedef enum logic [2:0] {ST_IDLE, ST_FETCH, ST_SAMPLE, ST_NEXT, ST_HALT} acf_state_t;

	typedef struct packed {
		logic psel;
		logic penable;
		logic pwrite;
		logic [ACF_ADDR_W-1:0] paddr;
		logic [ACF_DATA_W-1:0] pwdata;
	} acf_apb_req_t;

	typedef struct packed {
		logic req;
		logic [ACF_PTR_W-1:0] addr;
	} acf_fetch_t;
endpackage

// file: verification/acf_cmd_mem.sv
`timescale 1ns/1ps
module acf_cmd_mem #(
	parameter int DELAY = 2
)(
	// clock and reset
	input wire logic sys_clk,
	input wire logic resetn,
	// fetch link
	input acf_pkg::acf_fetch_t fetch,
	output logic fetchAck,
	output logic [acf_pkg::ACF_DATA_W-1:0] fetchData
);
	import acf_pkg::*;
	logic [7:0] cmds [128];
	logic [ACF_DATA_W-1:0] lastData;
	int waitCnt;
	// data line shows a changed value outside the answer cycle
	assign fetchData = fetchAck ? {16'h0000, cmds[fetch.addr[8:2]], 8'h00} : ~lastData;
	always_ff @(posedge sys_clk or negedge resetn)
		if (!resetn)
		begin
			fetchAck <= 1'b0;
			waitCnt <= 0;
			lastData <= 32'h0;
		end
		else if (fetchAck)
		begin
			fetchAck <= 1'b0;
			waitCnt <= 0;
			lastData <= fetchData;
		end
		else if (fetch.req)
		begin
			if (waitCnt == DELAY)
				fetchAck <= 1'b1;
			else
				waitCnt <= waitCnt + 1;
		end
endmodule

// file: verification/adc_command_fetch_sample_time_tb.sv
`timescale 1ns/1ps
module adc_command_fetch_sample_time_tb;
	import acf_pkg::*;
	logic sys_clk = 1'b0;
	logic resetn = 1'b0;
	acf_apb_req_t req = '0;
	logic pready, pslverr, fetchAck, sampling, halted, err;
	logic [31:0] prdata, fetchData, rd;
	acf_fetch_t fetch;
	int mismatches = 0;
	int compares = 0;
	acf_cmd_fetch #(.LIST1_OFFSET('h100)) uut (.sys_clk(sys_clk), .resetn(resetn),
		.apbReq(req), .pready(pready), .prdata(prdata), .pslverr(pslverr), .fetch(fetch),
		.fetchAck(fetchAck), .fetchData(fetchData), .sampling(sampling), .halted(halted));
	acf_cmd_mem #(.DELAY(3)) mem (.sys_clk(sys_clk), .resetn(resetn), .fetch(fetch),
		.fetchAck(fetchAck), .fetchData(fetchData));
	initial
		forever #4 sys_clk = ~sys_clk;
	task end_sim;
		if (mismatches == 0 && compares > 0)
			$display("Result: passed");
		else
			$display("Result: failed");
		$finish;
	endtask
	task chk(input logic [31:0] got, input logic [31:0] exp);
		compares++;
		if (got !== exp)
		begin
			mismatches++;
			$display("mismatch at %0t: got %h expected %h", $time, got, exp);
		end
	endtask
	task apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
		req <= '{1'b1, 1'b0, wr, a, d};
		@(posedge sys_clk);
		req.penable <= 1'b1;
		@(posedge sys_clk);
		while (pready !== 1'b1)
			@(posedge sys_clk);
		rd = prdata;
		err = pslverr;
		req <= '0;
		@(posedge sys_clk);
	endtask
	task rdchk(input logic [7:0] a, input logic [31:0] exp);
		apb(1'b0, a, 32'h0);
		chk(rd, exp);
	endtask
	task wfetch(input logic [23:0] exp);
		for (int i = 0; i < 100 && fetch.req !== 1'b1; i++)
			@(posedge sys_clk);
		chk(fetch.req, 1);
		chk(fetch.addr, exp);
	endtask
	task wsample(input int exp, input int p);
		int n;
		n = 0;
		for (int i = 0; i < 100 && sampling !== 1'b1; i++)
			@(posedge sys_clk);
		while (sampling === 1'b1 && n < 1000)
		begin
			n++;
			@(posedge sys_clk);
		end
		chk((n + p) / (p + 1), exp);
	endtask
	task whalt;
		for (int i = 0; i < 100 && halted !== 1'b1; i++)
			@(posedge sys_clk);
		chk(halted, 1);
		chk(sampling, 0);
	endtask
	task regs;
		rdchk(ACF_A_STAT, 32'h0);
		apb(1'b1, ACF_A_CIDX, 32'h5);
		rdchk(ACF_A_CIDX, 32'h0);
		apb(1'b1, ACF_A_CBP, 32'h00ffffff);
		rdchk(ACF_A_CBP, 32'h00fffffc);
		apb(1'b1, ACF_A_CBP, 32'h00000400);
		apb(1'b1, ACF_A_CMD2, 32'ha0);
		rdchk(ACF_A_CMD2, 32'h0);
		apb(1'b1, ACF_A_CTRL, 32'h2);
		apb(1'b1, ACF_A_CMD2, 32'h58);
		rdchk(ACF_A_CMD2, 32'h58);
		rdchk(8'hfc, 32'h0);
		chk(err, 1);
	endtask
	task run0;
		apb(1'b1, ACF_A_CTRL, 32'h0201);
		wfetch(24'h400);
		wsample(4, 2);
		wfetch(24'h404);
		wsample(24, 2);
		wfetch(24'h408);
		whalt;
		rdchk(ACF_A_STAT, 32'h3);
		rdchk(ACF_A_CIDX, 32'h2);
		apb(1'b1, ACF_A_CBP, 32'h0);
		rdchk(ACF_A_CBP, 32'h400);
		apb(1'b1, ACF_A_CTRL, 32'h0);
		apb(1'b1, ACF_A_STAT, 32'h1);
		rdchk(ACF_A_STAT, 32'h0);
		chk(halted, 0);
	endtask
	task run1;
		apb(1'b1, ACF_A_CTRL, 32'h5);
		wfetch(24'h500);
		whalt;
		rdchk(ACF_A_CIDX, 32'h0);
		apb(1'b1, ACF_A_CTRL, 32'h0);
		apb(1'b1, ACF_A_STAT, 32'h1);
	endtask
	initial
	begin
		mem.cmds[0] = 8'h00;
		mem.cmds[1] = 8'ha0;
		mem.cmds[2] = 8'ha8;
		mem.cmds[64] = 8'h01;
		repeat (2) @(posedge sys_clk);
		resetn <= 1'b1;
		@(posedge sys_clk);
		regs;
		run0;
		run1;
		end_sim;
	end
	initial
	begin
		#100000;
		mismatches++;
		end_sim;
	end
endmodule
